// *** rtl/fault_pkg.sv ***
package fault_pkg;

    // word geometry
    localparam int WORD_W = 16;
    localparam int NCH_DEFAULT = 8;

    // module fault summary word positions (15..11 is the summary field)
    localparam int MF_GROUP_BIT = 15;
    localparam int MF_CALIBRATING_BIT = 12;
    localparam int MF_CAL_ERR_BIT = 11;

    // floating point channel status word positions
    localparam int ST_HIGH_BIT = 0;
    localparam int ST_LOW_BIT = 1;
    localparam int ST_SLEW_BIT = 2;
    localparam int ST_HOLD_BIT = 3;
    localparam int ST_CAL_ERR_BIT = 4;
    localparam int ST_NAN_BIT = 5;
    localparam int ST_UNUSED_BIT = 6;
    localparam int ST_LOOP_BIT = 7;

    // integer status word: channel 0 at the top pair, two bits per channel
    localparam int INT_LOOP_TOP = 15;
    localparam int INT_HOLD_TOP = 14;

    // fixed channel fault patterns and reset values
    localparam logic [15:0] COMM_FAULT_PATTERN = 16'hFFFF;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] CODE_RST = 16'h0000;

    // hold window is 0.1 % of full scale
    localparam int HOLD_TOL_DIV = 1000;

    // open loop detection needs more than 0.1 mA on a 20 mA span
    localparam int OPEN_MIN_UA = 100;
    localparam int RANGE_SPAN_UA = 20000;

    // IEEE single precision fields
    localparam int FP_SIGN_BIT = 31;
    localparam int FP_EXP_MSB = 30;
    localparam int FP_EXP_LSB = 23;
    localparam logic [7:0] FP_EXP_ONES = 8'hFF;

endpackage

// *** rtl/check_if.sv ***
`timescale 1ns/1ps

// operands and verdicts of one channel's value checks
interface check_if;
    logic [31:0] req_float;
    logic [31:0] high_lim;
    logic [31:0] low_lim;
    logic [15:0] req_code;
    logic [15:0] echo_code;
    logic [15:0] max_step;
    logic [15:0] full_scale;
    logic        is_nan;
    logic        above_high;
    logic        below_low;
    logic        in_window;
    logic        step_over;
    logic        above_min;

    modport user (
        output req_float, high_lim, low_lim, req_code, echo_code, max_step, full_scale,
        input  is_nan, above_high, below_low, in_window, step_over, above_min
    );
    modport calc (
        input  req_float, high_lim, low_lim, req_code, echo_code, max_step, full_scale,
        output is_nan, above_high, below_low, in_window, step_over, above_min
    );
endinterface

// *** rtl/value_checker.sv ***
`timescale 1ns/1ps

module value_checker (
    // operands in, verdicts out
    check_if.calc c
);

    // maps a float onto an unsigned key that sorts in numeric order
    function automatic logic [31:0] order_key(input logic [31:0] f);
        order_key = f[fault_pkg::FP_SIGN_BIT] ? ~f : {1'b1, f[30:0]};
    endfunction

    logic [15:0] diff;
    logic [15:0] tol;
    logic [31:0] min_prod;
    logic [15:0] open_min;

    always_comb begin
        c.is_nan = (c.req_float[fault_pkg::FP_EXP_MSB:fault_pkg::FP_EXP_LSB]
                    == fault_pkg::FP_EXP_ONES) && (c.req_float[22:0] != 23'h000000);
        c.above_high = !c.is_nan && (order_key(c.req_float) > order_key(c.high_lim));
        c.below_low = !c.is_nan && (order_key(c.req_float) < order_key(c.low_lim));
        diff = (c.req_code > c.echo_code) ? 16'(c.req_code - c.echo_code)
                                          : 16'(c.echo_code - c.req_code);
        tol = 16'(32'(c.full_scale) / fault_pkg::HOLD_TOL_DIV);
        min_prod = 32'(c.full_scale) * 32'(fault_pkg::OPEN_MIN_UA);
        open_min = 16'(min_prod / 32'(fault_pkg::RANGE_SPAN_UA));
        c.in_window = diff <= tol;
        c.step_over = diff > c.max_step;
        c.above_min = c.echo_code > open_min;
    end

endmodule

// *** rtl/fault_status_reporter.sv ***
`timescale 1ns/1ps

// What this block does
// - group fault summary bit set whenever any channel fault word bit is set.
// - calibrating summary bit while any channel calibrates; all channel fault bits set.
// - calibration error summary at bit 11 when any channel calibration error flag set.
// - summary bits 15..11 behave the same in both data formats.
// - float mode: channel fault bit on high/low limit or open loop.
// - during calibration channel fault word reads 000F or 00FF by channel count.
// - controller communication fault makes channel fault word read FFFF.
// - open loop flag bit 7 needs 0-20 mA range, over 0.1 mA; holds till repaired.
// - invalid float request sets bit 5 and output keeps its previous value.
// - calibration error during a channel's calibration sets its bit 4.
// - holding flag bit 3 while holding; clears when request within 0.1 % of full scale of echo.
// - low limit flag bit 1 while request below low limit; latch keeps it.
// - high limit flag bit 0 while request above high limit; latch keeps it.
// - either limit flag also sets the channel's channel fault bit.
// - float mode status bit 6 is always zero.
// - float mode has one status word per channel, nonzero on any fault.
// - integer mode channel fault bits follow patterns, else only open loop.
// - integer mode reports only hold and open loop, one word; cal summary stays.
// - integer word: open loop on odd bits, hold on even, channel 0 at top.
// - limit alarms only exist in floating point format.
module fault_status_reporter #(
    parameter int N_CH = fault_pkg::NCH_DEFAULT,
    parameter logic [15:0] FULL_SCALE = 16'hFFFF
) (
    // clock and reset
    input  wire logic                   CLOCK,
    input  wire logic                   RST_N,
    // module configuration and connection state
    input  wire logic                   FLOAT_MODE,
    input  wire logic                   COMM_FAULT,
    // per channel configuration
    input  wire logic [N_CH-1:0]        RANGE_0_20MA,
    input  wire logic [N_CH-1:0]        HOLD_ENABLE,
    input  wire logic [N_CH-1:0]        ALARM_EN,
    input  wire logic [N_CH-1:0]        LATCH_EN,
    input  wire logic [N_CH-1:0][31:0]  HIGH_LIMIT,
    input  wire logic [N_CH-1:0][31:0]  LOW_LIMIT,
    input  wire logic [N_CH-1:0][15:0]  MAX_STEP,
    // requests from the owner controller
    input  wire logic [N_CH-1:0][31:0]  REQ_VALUE,
    input  wire logic [N_CH-1:0][15:0]  REQ_CODE,
    input  wire logic [N_CH-1:0]        UNLATCH,
    input  wire logic [N_CH-1:0]        HOLD_START,
    // field side and calibration state
    input  wire logic [N_CH-1:0][15:0]  ECHO_CODE,
    input  wire logic [N_CH-1:0]        LOOP_OPEN,
    input  wire logic [N_CH-1:0]        CAL_ACTIVE,
    input  wire logic [N_CH-1:0]        CAL_ERROR,
    // output drive and fault reporting
    output logic      [N_CH-1:0][15:0]  DRIVE_CODE,
    output logic      [15:0]            MODULE_FAULT_SUMMARY_WORD,
    output logic      [15:0]            CHANNEL_FAULT_WORD,
    output logic      [N_CH-1:0][15:0]  CHANNEL_STATUS_WORD
);

    typedef struct packed {
        logic [N_CH-1:0]       loop_break_flag;
        logic [N_CH-1:0]       invalid_float_flag;
        logic [N_CH-1:0]       channel_cal_error_flag;
        logic [N_CH-1:0]       output_holding_flag;
        logic [N_CH-1:0]       slew_exceeded_flag;
        logic [N_CH-1:0]       low_clamp_alarm_flag;
        logic [N_CH-1:0]       high_clamp_alarm_flag;
        logic [N_CH-1:0]       cal_seen;
        logic [N_CH-1:0][15:0] drive;
        logic [15:0]           mod_word;
        logic [15:0]           chan_word;
        logic [N_CH-1:0][15:0] stat_word;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // verdicts of the per channel value checks
    logic [N_CH-1:0] is_nan;
    logic [N_CH-1:0] above_high;
    logic [N_CH-1:0] below_low;
    logic [N_CH-1:0] in_window;
    logic [N_CH-1:0] step_over;
    logic [N_CH-1:0] above_min;

    generate
        for (genvar g = 0; g < N_CH; g++) begin : g_chk
            check_if cif ();

            assign cif.req_float = REQ_VALUE[g];
            assign cif.high_lim = HIGH_LIMIT[g];
            assign cif.low_lim = LOW_LIMIT[g];
            assign cif.req_code = REQ_CODE[g];
            assign cif.echo_code = ECHO_CODE[g];
            assign cif.max_step = MAX_STEP[g];
            assign cif.full_scale = FULL_SCALE;

            assign is_nan[g] = cif.is_nan;
            assign above_high[g] = cif.above_high;
            assign below_low[g] = cif.below_low;
            assign in_window[g] = cif.in_window;
            assign step_over[g] = cif.step_over;
            assign above_min[g] = cif.above_min;

            value_checker u_chk (
                .c (cif.calc)
            );
        end
    endgenerate

    always_comb begin
        logic          any_cal;
        logic          keep;
        logic [15:0]   normal_word;
        logic [15:0]   ones_word;
        logic [15:0]   int_word;

        nxt_st = st_ff;
        keep = 1'b0;
        any_cal = |CAL_ACTIVE;
        normal_word = fault_pkg::WORD_RST;
        ones_word = fault_pkg::WORD_RST;
        int_word = fault_pkg::WORD_RST;

        for (int i = 0; i < N_CH; i++) begin
            // high limit: level, or held by latch until unlatched
            keep = LATCH_EN[i] && st_ff.high_clamp_alarm_flag[i] && !UNLATCH[i];
            nxt_st.high_clamp_alarm_flag[i] = FLOAT_MODE && ALARM_EN[i]
                && (above_high[i] || keep);

            // low limit: level, or held by latch until unlatched
            keep = LATCH_EN[i] && st_ff.low_clamp_alarm_flag[i] && !UNLATCH[i];
            nxt_st.low_clamp_alarm_flag[i] = FLOAT_MODE && ALARM_EN[i]
                && (below_low[i] || keep);

            // slew: held until echo reaches target, or until unlatched if latched
            if (LATCH_EN[i]) begin
                keep = st_ff.slew_exceeded_flag[i] && !UNLATCH[i];
            end else begin
                keep = st_ff.slew_exceeded_flag[i] && (ECHO_CODE[i] != REQ_CODE[i]);
            end
            nxt_st.slew_exceeded_flag[i] = FLOAT_MODE && ALARM_EN[i]
                && (step_over[i] || keep);

            // hold: a start event wins over the release in the same cycle
            nxt_st.output_holding_flag[i] = (HOLD_START[i] && HOLD_ENABLE[i])
                || (st_ff.output_holding_flag[i] && !in_window[i]);

            // invalid float request follows the current request
            nxt_st.invalid_float_flag[i] = is_nan[i];

            // output code only moves on a valid request outside hold
            if (!is_nan[i] && !nxt_st.output_holding_flag[i]) begin
                nxt_st.drive[i] = REQ_CODE[i];
            end

            // open loop: armed only on 0-20 mA with current flowing, kept while open
            nxt_st.loop_break_flag[i] = LOOP_OPEN[i]
                && ((RANGE_0_20MA[i] && above_min[i])
                    || st_ff.loop_break_flag[i]);

            // calibration error: cleared when a new calibration of the channel begins
            nxt_st.cal_seen[i] = CAL_ACTIVE[i];
            keep = st_ff.channel_cal_error_flag[i]
                && !(CAL_ACTIVE[i] && !st_ff.cal_seen[i]);
            nxt_st.channel_cal_error_flag[i] = (CAL_ACTIVE[i] && CAL_ERROR[i])
                || keep;
        end

        for (int i = 0; i < N_CH; i++) begin
            ones_word[i] = 1'b1;
            if (FLOAT_MODE) begin
                normal_word[i] = nxt_st.high_clamp_alarm_flag[i]
                    || nxt_st.low_clamp_alarm_flag[i]
                    || nxt_st.loop_break_flag[i];
            end else begin
                normal_word[i] = nxt_st.loop_break_flag[i];
            end
        end

        // channel fault word: communication fault, then calibration, then normal
        if (COMM_FAULT) begin
            nxt_st.chan_word = fault_pkg::COMM_FAULT_PATTERN;
        end else if (any_cal) begin
            nxt_st.chan_word = ones_word;
        end else begin
            nxt_st.chan_word = normal_word;
        end

        // module summary word, same in both formats
        nxt_st.mod_word = fault_pkg::WORD_RST;
        nxt_st.mod_word[fault_pkg::MF_GROUP_BIT] = |nxt_st.chan_word;
        nxt_st.mod_word[fault_pkg::MF_CALIBRATING_BIT] = any_cal;
        nxt_st.mod_word[fault_pkg::MF_CAL_ERR_BIT] =
            |nxt_st.channel_cal_error_flag;

        // status words
        for (int i = 0; i < N_CH; i++) begin
            int_word[fault_pkg::INT_LOOP_TOP - 2 * i] = nxt_st.loop_break_flag[i];
            int_word[fault_pkg::INT_HOLD_TOP - 2 * i] = nxt_st.output_holding_flag[i];
        end

        for (int i = 0; i < N_CH; i++) begin
            nxt_st.stat_word[i] = fault_pkg::WORD_RST;
            if (FLOAT_MODE) begin
                nxt_st.stat_word[i][fault_pkg::ST_HIGH_BIT] =
                    nxt_st.high_clamp_alarm_flag[i];
                nxt_st.stat_word[i][fault_pkg::ST_LOW_BIT] =
                    nxt_st.low_clamp_alarm_flag[i];
                nxt_st.stat_word[i][fault_pkg::ST_SLEW_BIT] =
                    nxt_st.slew_exceeded_flag[i];
                nxt_st.stat_word[i][fault_pkg::ST_HOLD_BIT] =
                    nxt_st.output_holding_flag[i];
                nxt_st.stat_word[i][fault_pkg::ST_CAL_ERR_BIT] =
                    nxt_st.channel_cal_error_flag[i];
                nxt_st.stat_word[i][fault_pkg::ST_NAN_BIT] =
                    nxt_st.invalid_float_flag[i];
                nxt_st.stat_word[i][fault_pkg::ST_UNUSED_BIT] = 1'b0;
                nxt_st.stat_word[i][fault_pkg::ST_LOOP_BIT] =
                    nxt_st.loop_break_flag[i];
            end else if (i == 0) begin
                nxt_st.stat_word[i] = int_word;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign DRIVE_CODE = st_ff.drive;
    assign MODULE_FAULT_SUMMARY_WORD = st_ff.mod_word;
    assign CHANNEL_FAULT_WORD = st_ff.chan_word;
    assign CHANNEL_STATUS_WORD = st_ff.stat_word;

endmodule

// *** testbench/owner_model.sv ***
`timescale 1ns/1ps

// owner controller: sends each request as a float and as its output code
module owner_model #(
    parameter int N = 4
) (
    // requests chosen by the bench
    input  wire logic [N-1:0][31:0] val,
    input  wire logic [N-1:0][15:0] code,
    // requests on the module inputs
    output logic      [N-1:0][31:0] req_value,
    output logic      [N-1:0][15:0] req_code
);
    assign req_value = val;
    assign req_code  = code;
endmodule

// *** testbench/fault_status_reporter_sva.sv ***
`timescale 1ns/1ps

module fault_status_reporter_sva #(
    parameter int N_CH = 8
) (
    // clock and reset
    input wire logic                  CLOCK,
    input wire logic                  RST_N,
    // watched inputs
    input wire logic                  FLOAT_MODE,
    input wire logic                  COMM_FAULT,
    input wire logic [N_CH-1:0]       ALARM_EN,
    input wire logic [N_CH-1:0][31:0] HIGH_LIMIT,
    input wire logic [N_CH-1:0][31:0] REQ_VALUE,
    input wire logic [N_CH-1:0]       CAL_ACTIVE,
    // watched outputs
    input wire logic [N_CH-1:0][15:0] DRIVE_CODE,
    input wire logic [15:0]           MODULE_FAULT_SUMMARY_WORD,
    input wire logic [15:0]           CHANNEL_FAULT_WORD,
    input wire logic [N_CH-1:0][15:0] CHANNEL_STATUS_WORD
);
    logic any_cal;
    logic any_b6;
    always_comb begin
        any_cal = 1'b0;
        any_b6  = 1'b0;
        for (int c = 0; c < N_CH; c++) begin
            any_cal = any_cal | CHANNEL_STATUS_WORD[c][4];
            any_b6  = any_b6 | CHANNEL_STATUS_WORD[c][6];
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    group_fault_a: assert property (MODULE_FAULT_SUMMARY_WORD[15] == (CHANNEL_FAULT_WORD != 16'h0000))
        else $error("group summary bit wrong");
    calib_pat_a: assert property ($past(|CAL_ACTIVE && !COMM_FAULT) |->
        CHANNEL_FAULT_WORD == ((16'h0001 << N_CH) - 16'h0001)) else $error("calibration pattern wrong");
    comm_pat_a: assert property ($past(COMM_FAULT) |-> CHANNEL_FAULT_WORD == 16'hFFFF)
        else $error("communication pattern wrong");
    calibrating_bit_a: assert property (MODULE_FAULT_SUMMARY_WORD[12] == $past(|CAL_ACTIVE))
        else $error("calibrating bit wrong");
    cal_summary_a: assert property ($past(FLOAT_MODE) |-> MODULE_FAULT_SUMMARY_WORD[11] == any_cal)
        else $error("calibration error summary wrong");
    spare_bits_a: assert property ((!any_b6 || !$past(FLOAT_MODE))
        && MODULE_FAULT_SUMMARY_WORD[14:13] == 2'b00
        && MODULE_FAULT_SUMMARY_WORD[10:0] == 11'h000) else $error("unused bit set");
    int_one_word_a: assert property ($past(!FLOAT_MODE) |-> CHANNEL_STATUS_WORD[N_CH-1:1] == '0)
        else $error("integer mode uses more than one word");
    nan_keep_a: assert property ($past(FLOAT_MODE && REQ_VALUE[0][30:23] == 8'hFF
        && REQ_VALUE[0][22:0] != 23'h0) |-> CHANNEL_STATUS_WORD[0][5] && $stable(DRIVE_CODE[0]))
        else $error("invalid float not handled");
    limit_fault_a: assert property ($past(FLOAT_MODE && !COMM_FAULT && !(|CAL_ACTIVE))
        && CHANNEL_STATUS_WORD[0][1:0] != 2'b00 |-> CHANNEL_FAULT_WORD[0]) else $error("limit not in fault");
    high_alarm_a: assert property ($past(FLOAT_MODE && ALARM_EN[0] && !REQ_VALUE[0][31]
        && !HIGH_LIMIT[0][31] && REQ_VALUE[0] > HIGH_LIMIT[0] && REQ_VALUE[0][30:23] != 8'hFF)
        |-> CHANNEL_STATUS_WORD[0][0]) else $error("high alarm missing");
    cover property (FLOAT_MODE && CHANNEL_STATUS_WORD[0][0]);
    cover property (CHANNEL_FAULT_WORD == 16'hFFFF);
    cover property (MODULE_FAULT_SUMMARY_WORD[11]);
endmodule

// *** testbench/fault_status_reporter_bench.sv ***
`timescale 1ns/1ps

module fault_status_reporter_bench;
    localparam int N = 4;
    logic               clock = 1'b0;
    logic               rst_n = 1'b0;
    logic               float_mode, comm_fault;
    logic [N-1:0]       range_0_20ma, hold_enable, alarm_en, latch_en, unlatch, hold_start;
    logic [N-1:0]       loop_open, cal_active, cal_error;
    logic [N-1:0][31:0] high_limit, low_limit, val, req_value;
    logic [N-1:0][15:0] max_step, code, req_code, echo_code, drive_code, csw;
    logic [15:0]        mfsw, cfw;
    logic [15:0]        old_code;
    int                 err_count = 0;
    int                 n_checks = 0;
    always #25 clock = ~clock;
    owner_model #(.N(N)) own_u (.val(val), .code(code), .req_value(req_value), .req_code(req_code));
    fault_status_reporter #(.N_CH(N)) dut_u (.CLOCK(clock), .RST_N(rst_n),
        .FLOAT_MODE(float_mode), .COMM_FAULT(comm_fault), .RANGE_0_20MA(range_0_20ma),
        .HOLD_ENABLE(hold_enable), .ALARM_EN(alarm_en), .LATCH_EN(latch_en),
        .HIGH_LIMIT(high_limit), .LOW_LIMIT(low_limit), .MAX_STEP(max_step),
        .REQ_VALUE(req_value), .REQ_CODE(req_code), .UNLATCH(unlatch), .HOLD_START(hold_start),
        .ECHO_CODE(echo_code), .LOOP_OPEN(loop_open), .CAL_ACTIVE(cal_active),
        .CAL_ERROR(cal_error), .DRIVE_CODE(drive_code), .MODULE_FAULT_SUMMARY_WORD(mfsw),
        .CHANNEL_FAULT_WORD(cfw), .CHANNEL_STATUS_WORD(csw));
    task automatic step();
        @(posedge clock);
        #2;
    endtask
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // open loop is only seen above 0.1 mA: code 327 on a 16 bit span
    function automatic logic lp(input int c);
        return loop_open[c] & range_0_20ma[c] & (echo_code[c] > 16'd327);
    endfunction
    function automatic logic [15:0] exp_st(input int c);
        logic [15:0] w;
        w = 16'h0000;
        if (float_mode) begin
            w[0] = alarm_en[c] & (val[c] > high_limit[c]);
            w[1] = alarm_en[c] & (val[c] < low_limit[c]);
            w[7] = lp(c);
        end else if (c == 0) begin
            for (int k = 0; k < N; k++) w[15-2*k] = lp(k);
        end
        return w;
    endfunction
    function automatic logic [15:0] exp_cfw();
        logic [15:0] w;
        logic [15:0] s;
        w = 16'h0000;
        for (int c = 0; c < N; c++) begin
            s = exp_st(c);
            w[c] = float_mode ? (s[0] | s[1] | s[7]) : lp(c);
        end
        if (|cal_active) w = (16'h0001 << N) - 16'h0001;
        if (comm_fault) w = 16'hFFFF;
        return w;
    endfunction
    task automatic check_all();
        logic [15:0] f;
        f = exp_cfw();
        for (int c = 0; c < N; c++) cmp("status", exp_st(c), csw[c]);
        for (int c = 0; c < N; c++) cmp("drive", code[c], drive_code[c]);
        cmp("chan fault", f, cfw);
        cmp("module", {f != 16'h0000, 2'b00, |cal_active, 12'h000}, mfsw);
    endtask
    initial begin
        repeat (2000) @(posedge clock);
        err_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h4822));
        {float_mode, comm_fault, range_0_20ma, hold_enable, alarm_en, latch_en} = '0;
        {unlatch, hold_start, loop_open, cal_active, cal_error} = '0;
        high_limit = {N{32'h40000000}};
        low_limit = {N{32'h3F800000}};
        max_step = {N{16'hFFFF}};
        val = {N{32'h3FC00000}};
        code = '0;
        echo_code = '0;
        repeat (12) @(posedge clock);
        #2;
        cmp("module rst", 16'h0000, mfsw);
        cmp("chan rst", 16'h0000, cfw);
        rst_n = 1'b1;
        repeat (60) begin
            float_mode = 1'($urandom);
            comm_fault = ($urandom % 8) == 0;
            cal_active = (($urandom % 6) == 0) ? N'($urandom) : '0;
            alarm_en = N'($urandom);
            range_0_20ma = N'($urandom);
            loop_open = N'($urandom);
            for (int c = 0; c < N; c++) begin
                val[c] = {1'b0, 8'h7E + 8'($urandom % 4), 23'($urandom)};
                code[c] = 16'd300 + 16'($urandom % 56);
            end
            echo_code = code;
            step();
            check_all();
            loop_open = '0;
            step();
        end
        comm_fault = 1'b0;
        cal_active = '0;
        float_mode = 1'b1;
        alarm_en = '1;
        latch_en = 4'h2;
        val = {N{32'h3FC00000}};
        val[1] = 32'h40800000;
        step();
        cmp("latch set", 16'h0001, csw[1]);
        val[1] = 32'h3FC00000;
        step();
        cmp("latch kept", 16'h0001, csw[1]);
        unlatch[1] = 1'b1;
        step();
        cmp("unlatched", 16'h0000, csw[1]);
        unlatch = '0;
        alarm_en[0] = 1'b0;
        val[0] = 32'h7FC00000;
        old_code = code[0];
        code[0] = ~code[0];
        step();
        cmp("invalid float", 16'h0020, csw[0]);
        cmp("nan drive", old_code, drive_code[0]);
        val[0] = 32'h3FC00000;
        float_mode = 1'b0;
        hold_enable = '1;
        old_code = code[2];
        code[2] = 16'd1000;
        echo_code[2] = 16'd2000;
        hold_start[2] = 1'b1;
        step();
        hold_start = '0;
        cmp("int hold", 16'h0400, csw[0]);
        cmp("hold drive", old_code, drive_code[2]);
        step();
        cmp("int hold kept", 16'h0400, csw[0]);
        echo_code[2] = 16'd1065;
        step();
        cmp("int hold done", 16'h0000, csw[0]);
        cmp("hold release", 16'd1000, drive_code[2]);
        cmp("int chan fault", 16'h0000, cfw);
        {float_mode, hold_enable} = {1'b1, 4'h0};
        max_step[3] = 16'd10;
        code[3] = 16'd1000;
        echo_code[3] = 16'd500;
        step();
        cmp("slew set", 16'h0004, csw[3]);
        echo_code[3] = 16'd995;
        step();
        cmp("slew kept", 16'h0004, csw[3]);
        echo_code[3] = 16'd1000;
        step();
        cmp("slew done", 16'h0000, csw[3]);
        {cal_active[1], cal_error[1]} = 2'b11;
        step();
        cmp("cal chan fault", 16'h000F, cfw);
        cmp("cal module", 16'h9800, mfsw);
        cmp("cal status", 16'h0010, csw[1]);
        {cal_active[1], cal_error[1]} = 2'b00;
        step();
        cmp("cal kept", 16'h0800, mfsw);
        {comm_fault, cal_active[1]} = 2'b11;
        step();
        cmp("comm wins", 16'hFFFF, cfw);
        end_sim();
    end
endmodule

bind fault_status_reporter fault_status_reporter_sva #(.N_CH(N_CH)) sva_u (.CLOCK(CLOCK),
    .RST_N(RST_N), .FLOAT_MODE(FLOAT_MODE), .COMM_FAULT(COMM_FAULT), .ALARM_EN(ALARM_EN),
    .HIGH_LIMIT(HIGH_LIMIT), .REQ_VALUE(REQ_VALUE), .CAL_ACTIVE(CAL_ACTIVE),
    .DRIVE_CODE(DRIVE_CODE), .MODULE_FAULT_SUMMARY_WORD(MODULE_FAULT_SUMMARY_WORD),
    .CHANNEL_FAULT_WORD(CHANNEL_FAULT_WORD), .CHANNEL_STATUS_WORD(CHANNEL_STATUS_WORD));
